// [sctl_core.sv]
// Functional notes
// - system clock from one of five sources
// - pll reference any oscillator, crystals 3.58-16.38 MHz
// - sleep keeps clocking, stops processor clock
// - deep-sleep stops processor, drops pll, uses selected oscillator
// - sleep on request; WAKE_IRQ or any enabled interrupt returns run
// - chip reset on five listed events
// - record and report reset cause; configurable events
// - per-peripheral enable, disable and reset
// - separate sleep and deep-sleep clocked peripheral sets
// - seven system interrupt sources
// - per-source enable; pending until handler clears
// - read-only memory size, peripheral, pin information
// - adc rate request, hardware limit, actual readback
// - peripherals at processor rate, pwm own divider
`timescale 1ns/1ps
`default_nettype none

module sctl_core #(
    parameter int                      NP          = 16,
    parameter int                      NPINS       = 8,
    parameter logic [15:0]             FLASH_KB    = 16'h0040,
    parameter logic [15:0]             SRAM_KB     = 16'h0010,
    parameter logic [NP-1:0]           PERIPH_HAVE = '1,
    parameter logic [NPINS-1:0]        PINS_HAVE   = '1,
    parameter sctl_pkg::sctl_adc_rate_t ADC_LIMIT  = sctl_pkg::adc_rate_one_msps
) (
    input  wire logic                     CLK,
    input  wire logic                     SRST,
    input  wire sctl_pkg::sctl_clk_cfg_t  CLK_CFG,
    input  wire logic                     CLK_GATING_EN,
    input  wire logic                     SLEEP_REQ,
    input  wire logic                     DEEPSLEEP_REQ,
    input  wire logic                     WAKE_IRQ,
    input  wire logic [NP-1:0]            PERIPH_EN_SET,
    input  wire logic [NP-1:0]            PERIPH_EN_CLR,
    input  wire logic [NP-1:0]            PERIPH_RST_REQ,
    input  wire logic [NP-1:0]            SLEEP_PERIPH_EN,
    input  wire logic [NP-1:0]            DEEP_PERIPH_EN,
    input  wire logic                     SW_RESET_REQ,
    input  wire logic                     WDOG_TIMEOUT,
    input  wire logic                     RST_CFG_VIN_EN,
    input  wire logic                     RST_CFG_LDO_EN,
    input  wire logic                     VIN_LOW_IN,
    input  wire logic                     LDO_LOW_IN,
    input  wire logic                     EXT_RST_IN,
    input  wire logic                     PLL_LOCK_IN,
    input  wire logic                     LDO_ILIM_IN,
    input  wire logic                     INTOSC_FAIL_IN,
    input  wire logic                     MAINOSC_FAIL_IN,
    input  wire logic                     PLL_FAIL_IN,
    input  wire logic [6:0]               INT_ENABLE,
    input  wire logic [6:0]               INT_CLEAR,
    input  wire logic [4:0]               CAUSE_CLEAR,
    input  wire sctl_pkg::sctl_adc_rate_t ADC_RATE_REQ,
    output var  logic [2:0]               SYSCLK_SRC,
    output var  logic [1:0]               PLL_REF_SRC,
    output var  logic                     PLL_PWR_EN,
    output var  logic                     PLL_CFG_OK,
    output var  logic                     CPU_CLK_EN,
    output var  logic [NP-1:0]            PERIPH_CLK_EN,
    output var  logic                     PWM_CLK_EN,
    output var  logic [NP-1:0]            PERIPH_RST,
    output var  logic [NP-1:0]            PERIPH_EN_STAT,
    output var  sctl_pkg::sctl_mode_t     MODE,
    output var  logic                     CHIP_RST,
    output var  logic [4:0]               RESET_CAUSE,
    output var  logic [6:0]               INT_RAW,
    output var  logic [6:0]               INT_MASKED,
    output var  logic                     IRQ,
    output var  sctl_pkg::sctl_adc_rate_t ADC_RATE,
    output var  logic [15:0]              FLASH_SIZE_KB,
    output var  logic [15:0]              SRAM_SIZE_KB,
    output var  logic [NP-1:0]            PERIPH_PRESENT,
    output var  logic [NPINS-1:0]         PIN_PRESENT
);
    if (NP < 1 || NP > 64) begin : g_chk_np
        $error("sctl_core: NP must be 1..64");
    end
    if (NPINS < 1) begin : g_chk_pins
        $error("sctl_core: NPINS must be at least 1");
    end

    localparam logic [sctl_pkg::CNT_W-1:0] PRST_LOAD = sctl_pkg::CNT_W'(sctl_pkg::PRST_CYC);
    localparam logic [sctl_pkg::CNT_W-1:0] CRST_LOAD = sctl_pkg::CNT_W'(sctl_pkg::CRST_CYC);

    // ---------------- asynchronous pins: three stages, change on agreement
    localparam int NA = sctl_pkg::NPIN_ASYNC;
    wire  [NA-1:0] apin = {PLL_FAIL_IN, MAINOSC_FAIL_IN, INTOSC_FAIL_IN, LDO_ILIM_IN,
                           PLL_LOCK_IN, EXT_RST_IN, LDO_LOW_IN, VIN_LOW_IN};
    logic [NA-1:0] s1_r;
    logic [NA-1:0] s2_r;
    logic [NA-1:0] s3_r;
    logic [NA-1:0] lvl_r;
    wire  [NA-1:0] agree = ~(s2_r ^ s3_r);
    wire  [NA-1:0] lvl_nxt = (agree & s3_r) | (~agree & lvl_r);
    wire  [NA-1:0] rise = lvl_nxt & ~lvl_r;

    always_ff @(posedge CLK) begin
        if (SRST) begin
            s1_r  <= '0;
            s2_r  <= '0;
            s3_r  <= '0;
            lvl_r <= '0;
        end else begin
            s1_r  <= apin;
            s2_r  <= s1_r;
            s3_r  <= s2_r;
            lvl_r <= lvl_nxt;
        end
    end

    // ---------------- chip reset generation and cause capture
    logic [sctl_pkg::CNT_W-1:0] crst_cnt_r;
    logic [4:0]                 cause_r;
    wire  [4:0] cause_evt;
    assign cause_evt[sctl_pkg::CAUSE_VIN]  = rise[sctl_pkg::AP_VIN_LOW] & RST_CFG_VIN_EN;
    assign cause_evt[sctl_pkg::CAUSE_LDO]  = rise[sctl_pkg::AP_LDO_LOW] & RST_CFG_LDO_EN;
    assign cause_evt[sctl_pkg::CAUSE_EXT]  = rise[sctl_pkg::AP_EXT_RST];
    assign cause_evt[sctl_pkg::CAUSE_SW]   = SW_RESET_REQ;
    assign cause_evt[sctl_pkg::CAUSE_WDOG] = WDOG_TIMEOUT;
    wire  any_rst_evt = |cause_evt;
    wire  [sctl_pkg::CNT_W-1:0] crst_nxt = any_rst_evt ? CRST_LOAD :
        (crst_cnt_r != '0) ? crst_cnt_r - {{(sctl_pkg::CNT_W-1){1'b0}}, 1'b1} : crst_cnt_r;
    wire  chip_rst_nxt = (crst_nxt != '0);

    // only the power-on reset clears the causes; chip resets leave them for software
    always_ff @(posedge CLK) begin
        if (SRST) begin
            crst_cnt_r  <= '0;
            CHIP_RST    <= 1'b0;
            cause_r     <= '0;
            RESET_CAUSE <= '0;
        end else begin
            crst_cnt_r  <= crst_nxt;
            CHIP_RST    <= chip_rst_nxt;
            cause_r     <= (cause_r & ~CAUSE_CLEAR) | cause_evt;
            RESET_CAUSE <= (cause_r & ~CAUSE_CLEAR) | cause_evt;
        end
    end

    // ---------------- interrupt sources
    wire [6:0] int_evt;
    assign int_evt[sctl_pkg::INT_PLL_LOCK]     = rise[sctl_pkg::AP_PLL_LOCK];
    assign int_evt[sctl_pkg::INT_LDO_ILIM]     = rise[sctl_pkg::AP_LDO_ILIM];
    assign int_evt[sctl_pkg::INT_INTOSC_FAIL]  = rise[sctl_pkg::AP_INTOSC_F];
    assign int_evt[sctl_pkg::INT_MAINOSC_FAIL] = rise[sctl_pkg::AP_MAINOSC_F];
    assign int_evt[sctl_pkg::INT_VIN_LOW]      = rise[sctl_pkg::AP_VIN_LOW];
    assign int_evt[sctl_pkg::INT_LDO_LOW]      = rise[sctl_pkg::AP_LDO_LOW];
    assign int_evt[sctl_pkg::INT_PLL_FAIL]     = rise[sctl_pkg::AP_PLL_FAIL];
    // a new event in the clearing cycle stays pending
    wire [6:0] int_raw_nxt = (INT_RAW & ~INT_CLEAR) | int_evt;
    wire [6:0] int_msk_nxt = int_raw_nxt & INT_ENABLE;

    always_ff @(posedge CLK) begin
        if (SRST) begin
            INT_RAW    <= '0;
            INT_MASKED <= '0;
            IRQ        <= 1'b0;
        end else begin
            INT_RAW    <= int_raw_nxt;
            INT_MASKED <= int_msk_nxt;
            IRQ        <= |int_msk_nxt;
        end
    end

    // ---------------- run / sleep / deep-sleep
    sctl_pkg::sctl_mode_t mode_nxt;
    wire wake = WAKE_IRQ | IRQ;

    always_comb begin
        mode_nxt = MODE;
        unique case (MODE)
            sctl_pkg::MODE_RUN: begin
                if (DEEPSLEEP_REQ) begin
                    mode_nxt = sctl_pkg::MODE_DEEP;
                end else if (SLEEP_REQ) begin
                    mode_nxt = sctl_pkg::MODE_SLEEP;
                end
            end
            sctl_pkg::MODE_SLEEP,
            sctl_pkg::MODE_DEEP: begin
                if (wake) begin
                    mode_nxt = sctl_pkg::MODE_RUN;
                end
            end
            default: mode_nxt = sctl_pkg::MODE_RUN;
        endcase
        if (chip_rst_nxt) begin
            mode_nxt = sctl_pkg::MODE_RUN;
        end
    end

    always_ff @(posedge CLK) begin
        if (SRST) begin
            MODE <= sctl_pkg::MODE_RUN;
        end else begin
            MODE <= mode_nxt;
        end
    end

    // ---------------- clock source selection
    wire in_deep  = (mode_nxt == sctl_pkg::MODE_DEEP);
    wire xtal_ok  = (CLK_CFG.xtal >= sctl_pkg::XTAL_PLL_MIN) &&
                    (CLK_CFG.xtal <= sctl_pkg::XTAL_PLL_MAX);
    wire pll_want = CLK_CFG.use_pll & xtal_ok & ~in_deep;
    // switch to the pll only once lock is seen, so the core never runs on an unsettled clock
    wire [2:0] src_nxt = (pll_want & lvl_r[sctl_pkg::AP_PLL_LOCK]) ? sctl_pkg::SRC_PLL :
                         {1'b0, CLK_CFG.osc_src};

    always_ff @(posedge CLK) begin
        if (SRST) begin
            SYSCLK_SRC  <= {1'b0, sctl_pkg::OSC_INT};
            PLL_REF_SRC <= sctl_pkg::OSC_MAIN;
            PLL_PWR_EN  <= 1'b0;
            PLL_CFG_OK  <= 1'b0;
        end else begin
            SYSCLK_SRC  <= src_nxt;
            PLL_REF_SRC <= CLK_CFG.osc_src;
            PLL_PWR_EN  <= pll_want;
            PLL_CFG_OK  <= xtal_ok;
        end
    end

    // ---------------- system and pwm rates
    logic sys_tick;
    logic pwm_tick;

    sctl_tick_div #(
        .W (6)
    ) u_sysdiv (
        .clk  (CLK),
        .srst (SRST),
        .en   (1'b1),
        .div  (CLK_CFG.sysdiv),
        .tick (sys_tick)
    );

    sctl_tick_div #(
        .W (3)
    ) u_pwmdiv (
        .clk  (CLK),
        .srst (SRST),
        .en   (sys_tick),
        .div  (CLK_CFG.pwmdiv),
        .tick (pwm_tick)
    );

    // ---------------- peripheral enables, gating and resets
    logic [NP-1:0]              prst_pend_r;
    logic [sctl_pkg::CNT_W-1:0] prst_cnt_r;
    wire  [NP-1:0] en_nxt = (PERIPH_EN_STAT & ~PERIPH_EN_CLR) | PERIPH_EN_SET;
    wire  any_prst = |PERIPH_RST_REQ;
    wire  [sctl_pkg::CNT_W-1:0] prst_cnt_nxt = any_prst ? PRST_LOAD :
        (prst_cnt_r != '0) ? prst_cnt_r - {{(sctl_pkg::CNT_W-1){1'b0}}, 1'b1} : prst_cnt_r;
    wire  [NP-1:0] prst_nxt = (prst_cnt_nxt != '0) ?
        ((prst_pend_r | PERIPH_RST_REQ) & {NP{prst_cnt_nxt != '0}}) : '0;
    // without automatic gating every enabled peripheral keeps running in both sleep modes
    wire  [NP-1:0] gate_set =
        (MODE == sctl_pkg::MODE_RUN || !CLK_GATING_EN) ? PERIPH_EN_STAT :
        (MODE == sctl_pkg::MODE_SLEEP) ? SLEEP_PERIPH_EN : DEEP_PERIPH_EN;
    wire  [NP-1:0] pclk_nxt = gate_set & ~PERIPH_RST & {NP{sys_tick}} & PERIPH_HAVE;

    always_ff @(posedge CLK) begin
        if (SRST || CHIP_RST) begin
            PERIPH_EN_STAT <= '0;
            prst_pend_r    <= '0;
            prst_cnt_r     <= '0;
            PERIPH_RST     <= '0;
            PERIPH_CLK_EN  <= '0;
            CPU_CLK_EN     <= 1'b0;
            PWM_CLK_EN     <= 1'b0;
        end else begin
            PERIPH_EN_STAT <= en_nxt & PERIPH_HAVE;
            prst_pend_r    <= prst_nxt;
            prst_cnt_r     <= prst_cnt_nxt;
            PERIPH_RST     <= prst_nxt;
            PERIPH_CLK_EN  <= pclk_nxt;
            CPU_CLK_EN     <= sys_tick & (MODE == sctl_pkg::MODE_RUN);
            PWM_CLK_EN     <= pwm_tick;
        end
    end

    // ---------------- adc rate and identification
    // a larger code is a slower rate, so the slower of request and limit wins
    wire sctl_pkg::sctl_adc_rate_t adc_nxt = (ADC_RATE_REQ > ADC_LIMIT) ? ADC_RATE_REQ : ADC_LIMIT;

    always_ff @(posedge CLK) begin
        if (SRST) begin
            ADC_RATE       <= sctl_pkg::adc_rate_one_msps;
            FLASH_SIZE_KB  <= '0;
            SRAM_SIZE_KB   <= '0;
            PERIPH_PRESENT <= '0;
            PIN_PRESENT    <= '0;
        end else begin
            ADC_RATE       <= adc_nxt;
            FLASH_SIZE_KB  <= FLASH_KB;
            SRAM_SIZE_KB   <= SRAM_KB;
            PERIPH_PRESENT <= PERIPH_HAVE;
            PIN_PRESENT    <= PINS_HAVE;
        end
    end
endmodule

`default_nettype wire

// [sctl_pkg.sv]
package sctl_pkg;

    // core clock period and the time-based counts derived from it
    localparam int CLK_PERIOD_PS = 4000;
    localparam int PRST_TIME_NS  = 64;
    localparam int PRST_CYC      = (PRST_TIME_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
    localparam int CRST_TIME_NS  = 1000;
    localparam int CRST_CYC      = (CRST_TIME_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
    localparam int CNT_W         = 8;

    // oscillator and system clock source codes
    localparam logic [1:0] OSC_MAIN = 2'h0;
    localparam logic [1:0] OSC_INT  = 2'h1;
    localparam logic [1:0] OSC_INT4 = 2'h2;
    localparam logic [1:0] OSC_EXT  = 2'h3;
    localparam logic [2:0] SRC_PLL  = 3'h4;

    // crystal index window in which the pll may run (3.579545 .. 16.384 MHz)
    localparam logic [4:0] XTAL_PLL_MIN = 5'h04;
    localparam logic [4:0] XTAL_PLL_MAX = 5'h16;

    // interrupt source bit positions
    localparam int NINT             = 7;
    localparam int INT_PLL_LOCK     = 0;
    localparam int INT_LDO_ILIM     = 1;
    localparam int INT_INTOSC_FAIL  = 2;
    localparam int INT_MAINOSC_FAIL = 3;
    localparam int INT_VIN_LOW      = 4;
    localparam int INT_LDO_LOW      = 5;
    localparam int INT_PLL_FAIL     = 6;

    // reset cause bit positions
    localparam int NCAUSE     = 5;
    localparam int CAUSE_VIN  = 0;
    localparam int CAUSE_LDO  = 1;
    localparam int CAUSE_EXT  = 2;
    localparam int CAUSE_SW   = 3;
    localparam int CAUSE_WDOG = 4;

    // asynchronous pin positions in the synchroniser bank
    localparam int NPIN_ASYNC   = 8;
    localparam int AP_VIN_LOW   = 0;
    localparam int AP_LDO_LOW   = 1;
    localparam int AP_EXT_RST   = 2;
    localparam int AP_PLL_LOCK  = 3;
    localparam int AP_LDO_ILIM  = 4;
    localparam int AP_INTOSC_F  = 5;
    localparam int AP_MAINOSC_F = 6;
    localparam int AP_PLL_FAIL  = 7;

    typedef enum logic [1:0] {
        adc_rate_one_msps     = 2'h0,
        adc_rate_half_msps    = 2'h1,
        adc_rate_quarter_msps = 2'h2,
        adc_rate_eighth_msps  = 2'h3
    } sctl_adc_rate_t;

    typedef enum logic [1:0] {
        MODE_RUN   = 2'h0,
        MODE_SLEEP = 2'h1,
        MODE_DEEP  = 2'h2
    } sctl_mode_t;

    typedef struct packed {
        logic       use_pll;
        logic [1:0] osc_src;
        logic [4:0] xtal;
        logic [5:0] sysdiv;
        logic [2:0] pwmdiv;
    } sctl_clk_cfg_t;

endpackage

// [sctl_tick_div.sv]
`timescale 1ns/1ps
`default_nettype none

// divides a stream of enable pulses by div+1, emitting one-cycle ticks
module sctl_tick_div #(
    parameter int W = 6
) (
    input  wire logic         clk,
    input  wire logic         srst,
    input  wire logic         en,
    input  wire logic [W-1:0] div,
    output var  logic         tick
);
    logic [W-1:0] cnt_r;
    logic [W-1:0] cnt_nxt;
    wire          wrap = (cnt_r >= div);

    // a shrinking divisor wraps at once instead of running the counter round
    assign cnt_nxt = wrap ? '0 : cnt_r + {{(W-1){1'b0}}, 1'b1};

    always_ff @(posedge clk) begin
        if (srst) begin
            cnt_r <= '0;
            tick  <= 1'b0;
        end else begin
            tick <= en & wrap;
            if (en) begin
                cnt_r <= cnt_nxt;
            end
        end
    end
endmodule

`default_nettype wire

// [sctl_analog_model.sv]
`timescale 1ns/1ps
`default_nettype none

// oscillator, supply and pll pins as seen from the control block
module sctl_analog_model #(
    parameter int LOCK_CYC = 12
) (
    input  wire logic       clk,
    input  wire logic       pll_pwr,
    input  wire logic [7:0] fault,
    output var  logic [7:0] pins
);
    logic [7:0] lock_cnt_r;

    // lock only after the loop settles; losing power drops it at once
    always_ff @(posedge clk) begin
        if (!pll_pwr)
            lock_cnt_r <= 8'h00;
        else if (lock_cnt_r != LOCK_CYC[7:0])
            lock_cnt_r <= lock_cnt_r + 8'h01;
    end

    always_comb begin
        pins = fault;
        pins[sctl_pkg::AP_PLL_LOCK] = fault[sctl_pkg::AP_PLL_LOCK] | (lock_cnt_r == LOCK_CYC[7:0]);
    end
endmodule

`default_nettype wire

// [sctl_monitor.sv]
`timescale 1ns/1ps
`default_nettype none

module sctl_monitor #(
    parameter int NP = 16
) (
    input wire logic                 CLK,
    input wire logic                 SRST,
    input wire logic                 SLEEP_REQ,
    input wire logic                 DEEPSLEEP_REQ,
    input wire logic                 WAKE_IRQ,
    input wire logic                 SW_RESET_REQ,
    input wire logic [NP-1:0]        PERIPH_RST_REQ,
    input wire logic [6:0]           INT_ENABLE,
    input wire logic [6:0]           INT_CLEAR,
    input wire logic [4:0]           CAUSE_CLEAR,
    input wire logic [2:0]           SYSCLK_SRC,
    input wire logic                 PLL_PWR_EN,
    input wire logic                 CPU_CLK_EN,
    input wire logic [NP-1:0]        PERIPH_RST,
    input wire sctl_pkg::sctl_mode_t MODE,
    input wire logic                 CHIP_RST,
    input wire logic [4:0]           RESET_CAUSE,
    input wire logic [6:0]           INT_RAW,
    input wire logic [6:0]           INT_MASKED,
    input wire logic                 IRQ
);
    default clocking cb @(posedge CLK);
    endclocking
    default disable iff (SRST);

    a_masked_and_enable: assert property ($stable(INT_ENABLE) |-> INT_MASKED == (INT_RAW & INT_ENABLE))
        else $error("masked status wrong");
    a_irq_from_masked: assert property (IRQ == (|INT_MASKED))
        else $error("irq wrong");
    a_raw_held: assert property ((($past(INT_RAW) & ~$past(INT_CLEAR)) & ~INT_RAW) == 7'h00)
        else $error("pending bit lost");
    a_clear_drops: assert property (|INT_CLEAR |=> (INT_RAW & $past(INT_CLEAR)) == 7'h00)
        else $error("pending bit not cleared");
    a_cause_held: assert property ((($past(RESET_CAUSE) & ~$past(CAUSE_CLEAR)) & ~RESET_CAUSE) == 5'h00)
        else $error("cause bit lost");
    a_sw_reset_cause: assert property (SW_RESET_REQ |=> CHIP_RST && RESET_CAUSE[3] && MODE == sctl_pkg::MODE_RUN)
        else $error("software reset missed");
    a_sleep_entry: assert property (SLEEP_REQ && !DEEPSLEEP_REQ && !WAKE_IRQ && !SW_RESET_REQ && !CHIP_RST
        && MODE == sctl_pkg::MODE_RUN |=> MODE == sctl_pkg::MODE_SLEEP)
        else $error("sleep not entered");
    a_wake_to_run: assert property (MODE != sctl_pkg::MODE_RUN && WAKE_IRQ |=> MODE == sctl_pkg::MODE_RUN)
        else $error("no wake");
    a_cpu_halted: assert property (MODE != sctl_pkg::MODE_RUN && $past(MODE) != sctl_pkg::MODE_RUN |-> !CPU_CLK_EN)
        else $error("cpu clocked in sleep");
    a_deep_drops_pll: assert property (MODE == sctl_pkg::MODE_DEEP && $past(MODE) == sctl_pkg::MODE_DEEP
        |-> !PLL_PWR_EN && SYSCLK_SRC != sctl_pkg::SRC_PLL)
        else $error("pll used in deep sleep");
    a_periph_rst_hold: assert property (PERIPH_RST_REQ[0] && !CHIP_RST |=> PERIPH_RST[0] [*8])
        else $error("peripheral reset short");
endmodule

bind sctl_core sctl_monitor #(.NP(NP)) u_mon (
    .CLK, .SRST, .SLEEP_REQ, .DEEPSLEEP_REQ, .WAKE_IRQ, .SW_RESET_REQ, .PERIPH_RST_REQ, .INT_ENABLE,
    .INT_CLEAR, .CAUSE_CLEAR, .SYSCLK_SRC, .PLL_PWR_EN, .CPU_CLK_EN, .PERIPH_RST, .MODE, .CHIP_RST,
    .RESET_CAUSE, .INT_RAW, .INT_MASKED, .IRQ
);

`default_nettype wire

// [test_system_control_clock_power_reset.sv]
`timescale 1ns/1ps
`default_nettype none

module test_system_control_clock_power_reset;
    localparam logic [15:0] HAVE = 16'h7fff;
    localparam logic [15:0] FKB  = 16'h0080;

    logic                     CLK = 1'b0, SRST = 1'b1, CLK_GATING_EN = 1'b0, WAKE_IRQ = 1'b0;
    logic                     SLEEP_REQ = 1'b0, DEEPSLEEP_REQ = 1'b0, SW_RESET_REQ = 1'b0, WDOG_TIMEOUT = 1'b0;
    logic                     RST_CFG_VIN_EN = 1'b0, RST_CFG_LDO_EN = 1'b0;
    sctl_pkg::sctl_clk_cfg_t  CLK_CFG = '0;
    logic [15:0]              PERIPH_EN_SET = '0, PERIPH_EN_CLR = '0, PERIPH_RST_REQ = '0;
    logic [15:0]              SLEEP_PERIPH_EN = '0, DEEP_PERIPH_EN = '0;
    logic [6:0]               INT_ENABLE = '0, INT_CLEAR = '0;
    logic [4:0]               CAUSE_CLEAR = '0;
    sctl_pkg::sctl_adc_rate_t ADC_RATE_REQ = sctl_pkg::adc_rate_one_msps;
    logic [7:0]               fault = '0, pins, PIN_PRESENT;
    logic                     VIN_LOW_IN, LDO_LOW_IN, EXT_RST_IN, PLL_LOCK_IN;
    logic                     LDO_ILIM_IN, INTOSC_FAIL_IN, MAINOSC_FAIL_IN, PLL_FAIL_IN;
    logic [2:0]               SYSCLK_SRC;
    logic [1:0]               PLL_REF_SRC;
    logic                     PLL_PWR_EN, PLL_CFG_OK, CPU_CLK_EN, PWM_CLK_EN, CHIP_RST, IRQ;
    logic [15:0]              PERIPH_CLK_EN, PERIPH_RST, PERIPH_EN_STAT, PERIPH_PRESENT;
    logic [15:0]              FLASH_SIZE_KB, SRAM_SIZE_KB, seen_pclk;
    sctl_pkg::sctl_mode_t     MODE;
    sctl_pkg::sctl_adc_rate_t ADC_RATE;
    logic [6:0]               INT_RAW, INT_MASKED;
    logic [4:0]               RESET_CAUSE;
    int                       n_mismatch = 0, check_count = 0, n_cpu, n_pwm, k;

    always #2 CLK = ~CLK;
    assign {PLL_FAIL_IN, MAINOSC_FAIL_IN, INTOSC_FAIL_IN, LDO_ILIM_IN} = pins[7:4];
    assign {PLL_LOCK_IN, EXT_RST_IN, LDO_LOW_IN, VIN_LOW_IN} = pins[3:0];

    sctl_core #(.FLASH_KB(FKB), .PERIPH_HAVE(HAVE), .ADC_LIMIT(sctl_pkg::adc_rate_half_msps)) uut (
        .CLK, .SRST, .CLK_CFG, .CLK_GATING_EN, .SLEEP_REQ, .DEEPSLEEP_REQ, .WAKE_IRQ, .PERIPH_EN_SET,
        .PERIPH_EN_CLR, .PERIPH_RST_REQ, .SLEEP_PERIPH_EN, .DEEP_PERIPH_EN, .SW_RESET_REQ, .WDOG_TIMEOUT,
        .RST_CFG_VIN_EN, .RST_CFG_LDO_EN, .VIN_LOW_IN, .LDO_LOW_IN, .EXT_RST_IN, .PLL_LOCK_IN, .LDO_ILIM_IN,
        .INTOSC_FAIL_IN, .MAINOSC_FAIL_IN, .PLL_FAIL_IN, .INT_ENABLE, .INT_CLEAR, .CAUSE_CLEAR, .ADC_RATE_REQ,
        .SYSCLK_SRC, .PLL_REF_SRC, .PLL_PWR_EN, .PLL_CFG_OK, .CPU_CLK_EN, .PERIPH_CLK_EN, .PWM_CLK_EN,
        .PERIPH_RST, .PERIPH_EN_STAT, .MODE, .CHIP_RST, .RESET_CAUSE, .INT_RAW, .INT_MASKED, .IRQ,
        .ADC_RATE, .FLASH_SIZE_KB, .SRAM_SIZE_KB, .PERIPH_PRESENT, .PIN_PRESENT
    );
    sctl_analog_model u_analog (.clk(CLK), .pll_pwr(PLL_PWR_EN), .fault(fault), .pins(pins));

    task automatic complete_run();
        $display("checks %0d mismatches %0d", check_count, n_mismatch);
        if (n_mismatch == 0 && check_count > 0)
            $display("TEST PASSED");
        else
            $display("TEST FAILED");
        $finish;
    endtask

    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        check_count++;
        if (seen !== exp) begin
            n_mismatch++;
            $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask

    task automatic need(input logic hit);
        if (hit !== 1'b1) begin
            n_mismatch++;
            complete_run();
        end
    endtask

    task automatic cyc(input int n);
        repeat (n) @(posedge CLK);
        #1;
    endtask

    // window lengths are multiples of both divider periods, so phase does not matter
    task automatic watch(input int n);
        n_cpu = 0;
        n_pwm = 0;
        seen_pclk = '0;
        repeat (n) begin
            cyc(1);
            n_cpu += CPU_CLK_EN;
            n_pwm += PWM_CLK_EN;
            seen_pclk |= PERIPH_CLK_EN;
        end
    endtask

    task automatic t_clk_src();
        int xs[3] = '{3, 23, 22};
        check(FLASH_SIZE_KB, FKB);
        check(SRAM_SIZE_KB, 16'h0010);
        check(PERIPH_PRESENT, HAVE);
        check(PIN_PRESENT, 8'hff);
        for (int s = 0; s < 4; s++) begin
            @(posedge CLK);
            CLK_CFG <= '{use_pll: 1'b0, osc_src: s[1:0], xtal: 5'h10, sysdiv: 6'h00, pwmdiv: 3'h0};
            cyc(3);
            check(SYSCLK_SRC, s);
        end
        foreach (xs[i]) begin
            @(posedge CLK);
            CLK_CFG <= '{use_pll: 1'b1, osc_src: 2'h2, xtal: xs[i][4:0], sysdiv: 6'h00, pwmdiv: 3'h0};
            for (k = 0; k < 40 && SYSCLK_SRC !== sctl_pkg::SRC_PLL; k++) cyc(1);
            check(PLL_CFG_OK, xs[i] == 22);
            check(SYSCLK_SRC, xs[i] == 22 ? 3'h4 : 3'h2);
            check(PLL_REF_SRC, 2'h2);
        end
    endtask

    task automatic t_rates();
        @(posedge CLK);
        CLK_GATING_EN <= 1'b1;
        SLEEP_PERIPH_EN <= 16'h0003;
        DEEP_PERIPH_EN <= 16'h0001;
        PERIPH_EN_SET <= 16'hffff;
        CLK_CFG.sysdiv <= 6'h01;
        CLK_CFG.pwmdiv <= 3'h1;
        @(posedge CLK);
        PERIPH_EN_SET <= 16'h0000;
        cyc(4);
        watch(20);
        check(n_cpu, 10);
        check(n_pwm, 5);
        check(seen_pclk, HAVE);
    endtask

    task automatic t_sleep(input logic deep, input logic [15:0] set);
        @(posedge CLK);
        SLEEP_REQ <= !deep;
        DEEPSLEEP_REQ <= deep;
        @(posedge CLK);
        SLEEP_REQ <= 1'b0;
        DEEPSLEEP_REQ <= 1'b0;
        #1 check(MODE, deep ? sctl_pkg::MODE_DEEP : sctl_pkg::MODE_SLEEP);
        watch(20);
        check(n_cpu, 0);
        check(seen_pclk, set);
        check(PLL_PWR_EN, !deep);
        check(SYSCLK_SRC, deep ? 3'h2 : 3'h4);
        @(posedge CLK);
        WAKE_IRQ <= 1'b1;
        @(posedge CLK);
        WAKE_IRQ <= 1'b0;
        #1 check(MODE, sctl_pkg::MODE_RUN);
    endtask

    task automatic t_periph();
        @(posedge CLK);
        PERIPH_EN_CLR <= 16'h0006;
        PERIPH_RST_REQ <= 16'h0001;
        @(posedge CLK);
        PERIPH_EN_CLR <= '0;
        PERIPH_RST_REQ <= '0;
        #1 check(PERIPH_EN_STAT, HAVE & 16'hfff9);
        check(PERIPH_RST, 16'h0001);
        for (k = 0; k < 40 && PERIPH_RST[0] === 1'b1; k++) cyc(1);
        check(k, sctl_pkg::PRST_CYC);
    endtask

    task automatic t_irq();
        int pin[7] = '{3, 4, 5, 6, 0, 1, 7};
        @(posedge CLK);
        CLK_CFG.use_pll <= 1'b0;
        INT_ENABLE <= 7'h55;
        cyc(2);
        @(posedge CLK);
        INT_CLEAR <= 7'h7f;
        for (int i = 0; i < 7; i++) begin
            @(posedge CLK);
            INT_CLEAR <= 7'h00;
            fault[pin[i]] <= 1'b1;
            // let the clear land first; pin must stand past the three-stage filter
            cyc(1);
            for (k = 0; k < 8 && INT_RAW[i] !== 1'b1; k++) cyc(1);
            need(INT_RAW[i]);
            check(INT_MASKED, (7'h01 << i) & 7'h55);
            check(IRQ, (i % 2) == 0);
            check(CHIP_RST, 1'b0);
            @(posedge CLK);
            fault[pin[i]] <= 1'b0;
            cyc(3);
            check(INT_RAW, 7'h01 << i);
            @(posedge CLK);
            INT_CLEAR <= 7'h01 << i;
            cyc(1);
            check(INT_RAW, 7'h00);
        end
    endtask

    // one reset event per call; earlier causes must survive the new reset
    task automatic t_cause(input int c, input logic [4:0] exp);
        @(posedge CLK);
        INT_CLEAR <= 7'h00;
        RST_CFG_VIN_EN <= 1'b1;
        RST_CFG_LDO_EN <= 1'b1;
        SW_RESET_REQ <= (c == 3);
        WDOG_TIMEOUT <= (c == 4);
        if (c < 3) fault[c] <= 1'b1;
        @(posedge CLK);
        SW_RESET_REQ <= 1'b0;
        WDOG_TIMEOUT <= 1'b0;
        #1;
        for (k = 0; k < 8 && CHIP_RST !== 1'b1; k++) cyc(1);
        need(CHIP_RST);
        check(RESET_CAUSE, exp);
        for (k = 0; k < 400 && CHIP_RST === 1'b1; k++) cyc(1);
        check(k, sctl_pkg::CRST_CYC);
        check(PERIPH_EN_STAT, 16'h0000);
        @(posedge CLK);
        fault <= '0;
    endtask

    initial begin
        repeat (4) @(posedge CLK);
        SRST <= 1'b0;
        #1 check(SYSCLK_SRC, 3'h1);
        cyc(1);
        check(MODE, sctl_pkg::MODE_RUN);
        t_clk_src();
        t_rates();
        t_sleep(1'b0, 16'h0003);
        t_sleep(1'b1, 16'h0001);
        t_periph();
        t_irq();
        for (int r = 0; r < 4; r++) begin
            @(posedge CLK);
            ADC_RATE_REQ <= sctl_pkg::sctl_adc_rate_t'(r);
            cyc(2);
            check(ADC_RATE, r < 1 ? 1 : r);
        end
        t_cause(3, 5'h08);
        t_cause(4, 5'h18);
        t_cause(0, 5'h19);
        t_cause(1, 5'h1b);
        t_cause(2, 5'h1f);
        @(posedge CLK);
        CAUSE_CLEAR <= 5'h05;
        @(posedge CLK);
        CAUSE_CLEAR <= 5'h00;
        #1 check(RESET_CAUSE, 5'h1a);
        complete_run();
    end

    initial begin
        repeat (20000) @(posedge CLK);
        n_mismatch++;
        complete_run();
    end
endmodule

`default_nettype wire
